/* rtl/iapl_pkg.sv */
// constants and types shared by the interrupt acknowledge and priority logic
package iapl_pkg;

  // ----------------------------------------------------------------
  // level encoding
  // ----------------------------------------------------------------
  localparam int LVL_W   = 3;  // programmable level width, 0 is the highest
  localparam int NUM_LVL = 8;  // number of programmable levels
  localparam int GRP_W   = 8;  // channels covered by one grouped mask register

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [LVL_W-1:0]   LVL_RST   = 3'h7;  // every channel at the lowest level
  localparam logic               MASK_RST  = 1'b1;  // every channel masked
  localparam logic [NUM_LVL-1:0] ISP_RST   = 8'h00; // nothing in service
  localparam logic [LVL_W:0]     NO_LVL    = 4'h8;  // in-service top when no level is set

  // ----------------------------------------------------------------
  // class of the request presented to the core
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    IAPL_CLS_NONE,
    IAPL_CLS_FATAL,
    IAPL_CLS_HIGH,
    IAPL_CLS_CHAN
  } iapl_class_e;

endpackage

/* rtl/iapl_ctrl.sv */
// interrupt acknowledge, restore, masking and priority judgment logic
//
// Behaviour
// - fatal acknowledge holds all interrupts until high return
// - fatal request delivered even with nesting flag set
// - fatal request has no restore; system reset
// - high acknowledge holds high and channel interrupts
// - high return with exception flag clear restores
// - return with exception flag set restores nothing
// - channel acknowledge loads acknowledged-channel hold register
// - channel acknowledge records level, holds lower ones
// - in-service levels changed by hardware only
// - low return with flag clear releases level
// - per-channel mask bit, one masks, zero enables
// - grouped mask view shares the same storage
// - grouped write of one masks that channel
// - masked requests stay latched, fire on unmask
// - clearing request flag discards latched request
// - fixed order fatal over high over channel
// - 3-bit channel level, zero highest, seven lowest
// - equal levels resolved by lowest channel number
// - higher-priority interrupts nest during service
// - equal or lower than in-service level waits
// - hold register untouched by high acknowledge, read-only
// - judgment continues while core holds off acknowledge
`timescale 1ns/10ps

module iapl_ctrl
  import iapl_pkg::*;
#(
  parameter int NUM_CH = 16,                      // channel count, multiple of GRP_W
  parameter int CH_W   = $clog2(NUM_CH),          // channel number width
  parameter int GRP_IW = $clog2(NUM_CH / GRP_W)   // grouped mask register index width
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 nrst_i,
  // request sources
  input  wire logic                 fatal_nonmaskable_request_i,
  input  wire logic                 high_level_maskable_request_i,
  input  wire logic [NUM_CH-1:0]    channel_interrupt_request_i,
  input  wire logic [NUM_CH-1:0]    channel_request_flag_clr_i,
  // per-channel mask view
  input  wire logic                 channel_mask_bit_we_i,
  input  wire logic [CH_W-1:0]      channel_mask_bit_idx_i,
  input  wire logic                 channel_mask_bit_i,
  // grouped mask view
  input  wire logic                 grouped_mask_register_we_i,
  input  wire logic [GRP_IW-1:0]    grouped_mask_register_idx_i,
  input  wire logic [GRP_W-1:0]     grouped_mask_register_i,
  // channel level programming
  input  wire logic                 channel_level_we_i,
  input  wire logic [CH_W-1:0]      channel_level_idx_i,
  input  wire logic [LVL_W-1:0]     channel_level_i,
  // core status and handshake
  input  wire logic                 interrupt_disable_flag_i,
  input  wire logic                 high_level_nesting_flag_i,
  input  wire logic                 exception_in_progress_flag_i,
  input  wire logic                 cpu_ack_i,
  input  wire logic                 high_level_return_instr_i,
  input  wire logic                 low_level_return_instr_i,
  // presentation to the core
  output logic                      irq_valid_o,
  output iapl_class_e               irq_class_o,
  output logic [CH_W-1:0]           irq_chan_o,
  // readable state
  output logic [CH_W-1:0]           acknowledged_channel_hold_o,
  output logic [NUM_LVL-1:0]        in_service_priority_state_o,
  output logic [NUM_CH-1:0]         channel_mask_bit_o,
  output logic [NUM_CH-1:0]         channel_request_flag_o,
  output logic                      fatal_request_flag_o,
  output logic                      high_request_flag_o,
  // controller status word bits
  output logic                      fatal_issued_o,
  output logic                      high_issued_o,
  output logic                      chan_issued_o,
  output logic                      fatal_active_o,
  output logic                      high_active_o,
  output logic                      chan_active_o
);

  // ----------------------------------------------------------------
  // helper: highest-priority level currently in service
  // ----------------------------------------------------------------
  // lowest set bit wins because level 0 is the highest priority
  function automatic logic [LVL_W:0] top_level(input logic [NUM_LVL-1:0] isp);
    logic [LVL_W:0] t;
    t = NO_LVL;
    for (int k = NUM_LVL - 1; k >= 0; k--) begin
      if (isp[k]) begin
        t = (LVL_W+1)'(k);
      end
    end
    return t;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0]    flag_q,  flag_d;    // latched channel requests
  logic                 fatal_q, fatal_d;   // latched fatal request
  logic                 high_q,  high_d;    // latched high-level request
  logic [NUM_CH-1:0]    mask_q,  mask_d;    // one storage for both mask views
  logic [LVL_W-1:0]     lvl_q    [NUM_CH];  // programmed channel levels
  logic [LVL_W-1:0]     lvl_d    [NUM_CH];
  logic [NUM_LVL-1:0]   isp_q,   isp_d;     // in-service level bitmap
  logic                 fne_q,   fne_d;     // core handling the fatal request
  logic                 fie_q,   fie_d;     // core handling the high request
  logic                 eie_q,   eie_d;     // core handling a channel request
  logic [CH_W-1:0]      scr_q,   scr_d;     // acknowledged channel number
  logic                 pv_q,    pv_d;      // presentation valid
  iapl_class_e          pc_q,    pc_d;      // presented class
  logic [CH_W-1:0]      pch_q,   pch_d;     // presented channel
  logic [LVL_W-1:0]     plv_q,   plv_d;     // level of presented channel

  // ----------------------------------------------------------------
  // judgment signals
  // ----------------------------------------------------------------
  logic                 ack;                // acknowledge of a valid presentation
  logic                 hi_ret_ok;          // high return that restores
  logic                 lo_ret_ok;          // low return that restores
  logic [LVL_W:0]       top;                // in-service top level
  logic                 best_found;         // an eligible channel exists
  logic [CH_W-1:0]      best_idx;           // winning channel
  logic [LVL_W-1:0]     best_lvl;           // its level

  assign ack       = cpu_ack_i && pv_q;
  assign hi_ret_ok = high_level_return_instr_i && !exception_in_progress_flag_i;
  assign lo_ret_ok = low_level_return_instr_i && !exception_in_progress_flag_i;
  assign top       = top_level(isp_q);

  // ----------------------------------------------------------------
  // channel arbitration, runs every cycle whatever the core flags
  // ----------------------------------------------------------------
  always_comb begin
    best_found = 1'b0;
    best_idx   = '0;
    best_lvl   = LVL_RST;
    for (int i = 0; i < NUM_CH; i++) begin
      // masked channels stay latched but never compete
      if (flag_q[i] && !mask_q[i] && ({1'b0, lvl_q[i]} < top)) begin
        // strict compare keeps the lower channel number on a tie
        if (!best_found || (lvl_q[i] < best_lvl)) begin
          best_found = 1'b1;
          best_idx   = CH_W'(i);
          best_lvl   = lvl_q[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // request, mask and level storage: next values
  // ----------------------------------------------------------------
  always_comb begin
    flag_d  = flag_q;
    fatal_d = fatal_q;
    high_d  = high_q;
    mask_d  = mask_q;
    lvl_d   = lvl_q;
    // clears first, so that a request in the same cycle wins
    flag_d = flag_d & ~channel_request_flag_clr_i;
    if (ack && (pc_q == IAPL_CLS_CHAN)) begin
      flag_d[pch_q] = 1'b0;
    end
    if (ack && (pc_q == IAPL_CLS_FATAL)) begin
      fatal_d = 1'b0;
    end
    if (ack && (pc_q == IAPL_CLS_HIGH)) begin
      high_d = 1'b0;
    end
    // requests latch even while held off or masked
    flag_d  = flag_d | channel_interrupt_request_i;
    fatal_d = fatal_d | fatal_nonmaskable_request_i;
    high_d  = high_d | high_level_maskable_request_i;
    // per-channel view of the mask
    if (channel_mask_bit_we_i) begin
      mask_d[channel_mask_bit_idx_i] = channel_mask_bit_i;
    end
    // grouped view writes the very same bits; it wins a same-cycle clash
    if (grouped_mask_register_we_i) begin
      for (int j = 0; j < GRP_W; j++) begin
        mask_d[int'(grouped_mask_register_idx_i) * GRP_W + j] =
          grouped_mask_register_i[j];
      end
    end
    if (channel_level_we_i) begin
      lvl_d[channel_level_idx_i] = channel_level_i;
    end
  end

  // ----------------------------------------------------------------
  // request, mask and level storage: registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_q  <= '0;
      fatal_q <= 1'b0;
      high_q  <= 1'b0;
      mask_q  <= {NUM_CH{MASK_RST}};
      for (int i = 0; i < NUM_CH; i++) begin
        lvl_q[i] <= LVL_RST;
      end
    end else begin
      flag_q  <= flag_d;
      fatal_q <= fatal_d;
      high_q  <= high_d;
      mask_q  <= mask_d;
      lvl_q   <= lvl_d;
    end
  end

  // ----------------------------------------------------------------
  // service and presentation state: next values
  // ----------------------------------------------------------------
  // there is no software write path into isp or scr at all
  always_comb begin
    isp_d = isp_q;
    fne_d = fne_q;
    fie_d = fie_q;
    eie_d = eie_q;
    scr_d = scr_q;
    pv_d  = 1'b0;
    pc_d  = IAPL_CLS_NONE;
    pch_d = pch_q;
    plv_d = plv_q;
    // high return releases the fatal and high holds, but the core
    // has nothing to return to after a fatal request
    if (hi_ret_ok) begin
      fie_d = 1'b0;
      fne_d = 1'b0;
    end
    // low return drops only the topmost in-service level
    if (lo_ret_ok && (top != NO_LVL)) begin
      isp_d[top[LVL_W-1:0]] = 1'b0;
    end
    // acknowledge updates the service state of the presented class
    if (ack) begin
      unique case (pc_q)
        IAPL_CLS_FATAL: fne_d = 1'b1;
        IAPL_CLS_HIGH:  fie_d = 1'b1;
        IAPL_CLS_CHAN: begin
          scr_d        = pch_q;
          isp_d[plv_q] = 1'b1;
        end
        IAPL_CLS_NONE:  fne_d = fne_d;
      endcase
    end
    eie_d = |isp_d;
    // presentation; dropped for one cycle after an acknowledge so the
    // same request is never taken twice
    if (!ack) begin
      if (fatal_q && !fne_q) begin
        // nesting and disable flags do not hold the fatal request
        pv_d = 1'b1;
        pc_d = IAPL_CLS_FATAL;
      end else if (high_q && !fne_q && !fie_q && !high_level_nesting_flag_i) begin
        pv_d = 1'b1;
        pc_d = IAPL_CLS_HIGH;
      end else if (best_found && !fne_q && !fie_q && !high_level_nesting_flag_i
                   && !interrupt_disable_flag_i) begin
        pv_d  = 1'b1;
        pc_d  = IAPL_CLS_CHAN;
        pch_d = best_idx;
        plv_d = best_lvl;
      end
    end
  end

  // ----------------------------------------------------------------
  // service and presentation state: registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      isp_q <= ISP_RST;
      fne_q <= 1'b0;
      fie_q <= 1'b0;
      eie_q <= 1'b0;
      scr_q <= '0;
      pv_q  <= 1'b0;
      pc_q  <= IAPL_CLS_NONE;
      pch_q <= '0;
      plv_q <= LVL_RST;
    end else begin
      isp_q <= isp_d;
      fne_q <= fne_d;
      fie_q <= fie_d;
      eie_q <= eie_d;
      scr_q <= scr_d;
      pv_q  <= pv_d;
      pc_q  <= pc_d;
      pch_q <= pch_d;
      plv_q <= plv_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign irq_valid_o                 = pv_q;
  assign irq_class_o                 = pc_q;
  assign irq_chan_o                  = pch_q;
  assign acknowledged_channel_hold_o = scr_q;
  assign in_service_priority_state_o = isp_q;
  assign channel_mask_bit_o          = mask_q;
  assign channel_request_flag_o      = flag_q;
  assign fatal_request_flag_o        = fatal_q;
  assign high_request_flag_o         = high_q;
  assign fatal_issued_o              = pv_q && (pc_q == IAPL_CLS_FATAL);
  assign high_issued_o               = pv_q && (pc_q == IAPL_CLS_HIGH);
  assign chan_issued_o               = pv_q && (pc_q == IAPL_CLS_CHAN);
  assign fatal_active_o              = fne_q;
  assign high_active_o               = fie_q;
  assign chan_active_o               = eie_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence fatal_taken_s;
    ack && (pc_q == IAPL_CLS_FATAL);
  endsequence

  sequence chan_taken_s;
    ack && (pc_q == IAPL_CLS_CHAN);
  endsequence

  sequence quiet_ret_s;
    !ack && (high_level_return_instr_i || low_level_return_instr_i)
      && exception_in_progress_flag_i;
  endsequence

  fatal_hold_a : assert property (
    fatal_taken_s ##1 (!hi_ret_ok)[*2] |=> !pv_q)
    else $error("interrupt presented while fatal request in service");

  fatal_nesting_a : assert property (
    (fatal_q && !fne_q && !ack && high_level_nesting_flag_i && interrupt_disable_flag_i)
      |=> pv_q && (pc_q == IAPL_CLS_FATAL))
    else $error("fatal request not presented under nesting flag");

  high_hold_a : assert property (
    (fie_q && !hi_ret_ok) |=> !(pv_q && (pc_q != IAPL_CLS_FATAL)))
    else $error("high or channel interrupt presented during high service");

  high_restore_a : assert property (
    (fie_q && hi_ret_ok && !ack) |=> !fie_q && !fne_q)
    else $error("high return did not clear service status");

  ep_keep_a : assert property (
    quiet_ret_s |=> (isp_q == $past(isp_q)) && (fie_q == $past(fie_q))
      && (fne_q == $past(fne_q)))
    else $error("return with exception flag set changed service state");

  hold_load_a : assert property (
    chan_taken_s |=> scr_q == $past(pch_q))
    else $error("acknowledged channel not held");

  hold_keep_a : assert property (
    (ack && (pc_q != IAPL_CLS_CHAN)) |=> $stable(scr_q))
    else $error("hold register changed on non-channel acknowledge");

  level_record_a : assert property (
    chan_taken_s |=> isp_q[$past(plv_q)] && eie_q)
    else $error("acknowledged level not recorded");

  low_release_a : assert property (
    (lo_ret_ok && !ack && (isp_q != ISP_RST))
      |=> $countones(isp_q) == $countones($past(isp_q)) - 1)
    else $error("low return did not release one level");

  flag_clear_a : assert property (
    (|(channel_request_flag_clr_i & ~channel_interrupt_request_i))
      |=> (flag_q & $past(channel_request_flag_clr_i & ~channel_interrupt_request_i)) == '0)
    else $error("cleared request flag still set");

  order_high_a : assert property (
    (high_q && !fatal_q && !fne_q && !fie_q && !high_level_nesting_flag_i && !ack)
      |=> pv_q && (pc_q == IAPL_CLS_HIGH))
    else $error("high request not presented over channels");

  chan_level_a : assert property (
    (pv_q && (pc_q == IAPL_CLS_CHAN)) |-> !isp_q[plv_q])
    else $error("channel at in-service level presented");

endmodule

/* tb/iapl_cpu_model.sv */
// core-side model: takes presented interrupts and executes return instructions
`timescale 1ns/10ps

module iapl_cpu_model
  import iapl_pkg::*;
#(
  parameter int CH_W = 4  // channel number width
) (
  // clock
  input  wire logic            clk_i,
  // presentation from the controller
  input  wire logic            irq_valid_i,
  input  wire iapl_class_e     irq_class_i,
  input  wire logic [CH_W-1:0] irq_chan_i,
  // handshake back to the controller
  output logic                 cpu_ack_o,
  output logic                 high_ret_o,
  output logic                 low_ret_o
);
  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  initial begin
    cpu_ack_o  = 1'b0;
    high_ret_o = 1'b0;
    low_ret_o  = 1'b0;
  end

  // ----------------------------------------------------------------
  // acknowledge and return
  // ----------------------------------------------------------------
  // ack goes up early and is held until an edge samples valid high or 50 edges have passed
  // dly lets the core answer promptly or slowly
  task automatic take(input int dly, output iapl_class_e cls, output logic [CH_W-1:0] ch,
                      output bit ok);
    int i;
    ok = 1'b0;
    repeat (dly) @(posedge clk_i);
    #1 cpu_ack_o = 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_i);
      if (irq_valid_i === 1'b1) begin
        cls = irq_class_i;
        ch  = irq_chan_i;
        ok  = 1'b1;
        break;
      end
    end
    #1 cpu_ack_o = 1'b0;
  endtask

  // one-cycle return pulse; a fatal entry has no way back to the old program,
  // the model only frees the controller with a high return
  task automatic ret(input logic hi);
    high_ret_o = hi;
    low_ret_o  = ~hi;
    @(posedge clk_i);
    #1 high_ret_o = 1'b0;
    low_ret_o = 1'b0;
  endtask
endmodule

/* tb/iapl_ctrl_test.sv */
// self-checking bench for the interrupt acknowledge and priority logic
`timescale 1ns/10ps

module iapl_ctrl_test;
  import iapl_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic              clk_i, nrst_i;          // clock and reset
  logic              fat_q, hi_q;            // fatal and high request inputs
  logic [15:0]       req, clr;               // channel request and clear
  logic              mwe, gwe, lwe, mbit;    // mask and level write strobes, and the mask bit
  logic [3:0]        midx, lidx;             // write indices
  logic              gidx;                   // group index
  logic [7:0]        gdat;                   // grouped mask data
  logic [2:0]        ldat;                   // level data
  logic              dis, nest, ep;          // core flags
  logic              ack, hret, lret;        // from the core model
  logic              vld;                    // presentation
  iapl_class_e       cls;
  logic [3:0]        chn, hold;
  logic [7:0]        isp;
  logic [15:0]       mask, flg;
  logic              fflg, hflg, fiss, hiss, ciss, fact, hact, cact;
  int                failures, comparisons;  // counters of the run
  logic [2:0]        lv [16];                // bench copy of channel levels
  logic [15:0]       em;                     // bench copy of the mask storage

  iapl_ctrl u_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .fatal_nonmaskable_request_i(fat_q),
    .high_level_maskable_request_i(hi_q), .channel_interrupt_request_i(req),
    .channel_request_flag_clr_i(clr), .channel_mask_bit_we_i(mwe),
    .channel_mask_bit_idx_i(midx), .channel_mask_bit_i(mbit),
    .grouped_mask_register_we_i(gwe), .grouped_mask_register_idx_i(gidx),
    .grouped_mask_register_i(gdat), .channel_level_we_i(lwe), .channel_level_idx_i(lidx),
    .channel_level_i(ldat), .interrupt_disable_flag_i(dis), .high_level_nesting_flag_i(nest),
    .exception_in_progress_flag_i(ep), .cpu_ack_i(ack), .high_level_return_instr_i(hret),
    .low_level_return_instr_i(lret), .irq_valid_o(vld), .irq_class_o(cls), .irq_chan_o(chn),
    .acknowledged_channel_hold_o(hold), .in_service_priority_state_o(isp),
    .channel_mask_bit_o(mask), .channel_request_flag_o(flg), .fatal_request_flag_o(fflg),
    .high_request_flag_o(hflg), .fatal_issued_o(fiss), .high_issued_o(hiss),
    .chan_issued_o(ciss), .fatal_active_o(fact), .high_active_o(hact), .chan_active_o(cact));

  iapl_cpu_model #(.CH_W(4)) u_cpu (
    .clk_i(clk_i), .irq_valid_i(vld), .irq_class_i(cls), .irq_chan_i(chn),
    .cpu_ack_o(ack), .high_ret_o(hret), .low_ret_o(lret));

  // ----------------------------------------------------------------
  // clock and helpers
  // ----------------------------------------------------------------
  always #50 clk_i = ~clk_i;  // 10 MHz

  // every drive lands 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // presented class and channel together
  task automatic chk_irq(input iapl_class_e e, input logic [3:0] c);
    chk("class", 16'(e), 16'(cls));
    if (e == IAPL_CLS_CHAN) chk("chan", 16'(c), 16'(chn));
  endtask

  task automatic results;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // core takes the request; a missing answer ends the run
  task automatic grab(input int d, input iapl_class_e e, input logic [3:0] c);
    iapl_class_e gc;
    logic [3:0]  gch;
    bit          ok;
    u_cpu.take(d, gc, gch, ok);
    if (!ok) begin
      failures++;
      results();
    end
    chk("taken class", 16'(e), 16'(gc));
    if (e == IAPL_CLS_CHAN) chk("taken chan", 16'(c), 16'(gch));
  endtask

  task automatic pulse_req(input logic [15:0] v);
    req = v;
    tick(1);
    req = '0;
  endtask

  task automatic set_lvl(input int c, input logic [2:0] l);
    lwe = 1'b1; lidx = 4'(c); ldat = l; lv[c] = l;
    tick(1);
    lwe = 1'b0;
  endtask

  task automatic clr_all;
    clr = '1;
    tick(1);
    clr = '0;
    tick(1);
  endtask

  // lowest level wins, then lowest channel number
  function automatic int win(input logic [15:0] p);
    int b;
    b = -1;
    for (int i = 0; i < 16; i++)
      if (p[i] && (b < 0 || lv[i] < lv[b])) b = i;
    return b;
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_i = 0; nrst_i = 0; fat_q = 0; hi_q = 0; req = '0; clr = '0;
    mwe = 0; gwe = 0; lwe = 0; mbit = 0; midx = '0; lidx = '0; gidx = 0;
    gdat = '0; ldat = '0; dis = 0; nest = 0; ep = 0; failures = 0; comparisons = 0;
    foreach (lv[i]) lv[i] = 3'h7;
    void'($urandom(85723));
    repeat (2) @(posedge clk_i);
    #1 nrst_i = 1;
    tick(1);
    chk("mask rst", 16'hffff, mask);
    chk("isp rst", 16'h0000, 16'(isp));
    chk("valid rst", 16'h0000, 16'(vld));
    $display("test reset done");
    // masked request stays latched and fires once unmasked
    pulse_req(16'h0020); tick(2);
    chk("flags", 16'h0020, flg);
    chk("valid", 16'h0000, 16'(vld));
    mwe = 1; midx = 4'h5; mbit = 0; tick(1); mwe = 0; tick(1);
    chk("valid", 16'h0001, 16'(vld));
    chk_irq(IAPL_CLS_CHAN, 4'h5);
    clr[5] = 1; tick(1); clr = '0; tick(1);
    chk("flags", 16'h0000, flg);
    chk("valid", 16'h0000, 16'(vld));
    gwe = 1; gidx = 0; gdat = 8'h20; tick(1); gwe = 0; tick(1);
    chk("mask", 16'hff20, mask);
    // random writes through both views must land in one storage
    em = 16'hff20;
    for (int t = 0; t < 4; t++) begin
      gidx = 1'($urandom);
      gdat = 8'($urandom);
      gwe = 1;
      tick(1);
      gwe = 0;
      em[8*gidx +: 8] = gdat;
      midx = 4'($urandom);
      mbit = 1'($urandom);
      mwe = 1;
      tick(1);
      mwe = 0;
      em[midx] = mbit;
      tick(1);
      chk("mask", em, mask);
    end
    gwe = 1; gidx = 1; gdat = 8'h00; tick(1);
    gidx = 0; tick(1); gwe = 0; tick(1);
    chk("mask", 16'h0000, mask);
    $display("test mask done");
    // random levels (all 3 in round 0) and random requests, judged while dis or nest holds the core off in six of the eight rounds
    for (int t = 0; t < 8; t++) begin
      for (int c = 0; c < 16; c++) set_lvl(c, (t == 0) ? 3'h3 : 3'($urandom_range(7, 0)));
      dis = t[0];
      nest = t[1];
      pulse_req(16'($urandom_range(16'hffff, 1))); tick(2);
      if (t[0] || t[1]) chk("held", 16'h0000, 16'(vld));
      dis = 0;
      nest = 0;
      tick(2);
      chk_irq(IAPL_CLS_CHAN, 4'(win(flg)));
      clr_all();
    end
    $display("test priority done");
    // channel service, nesting and release
    set_lvl(4, 3'h2); set_lvl(6, 3'h2); set_lvl(1, 3'h5); set_lvl(9, 3'h0);
    pulse_req(16'h0010); tick(1);
    grab(0, IAPL_CLS_CHAN, 4'h4); tick(1);
    chk("hold", 16'h0004, 16'(hold));
    chk("isp", 16'h0004, 16'(isp));
    chk("chan act", 16'h0001, 16'(cact));
    pulse_req(16'h0042); tick(2);
    chk("valid", 16'h0000, 16'(vld));
    chk("flags", 16'h0042, flg);
    pulse_req(16'h0200); tick(2);
    chk_irq(IAPL_CLS_CHAN, 4'h9);
    grab(2, IAPL_CLS_CHAN, 4'h9); tick(1);
    chk("isp", 16'h0005, 16'(isp));
    ep = 1; u_cpu.ret(1'b0); ep = 0; tick(1);
    chk("isp", 16'h0005, 16'(isp));
    u_cpu.ret(1'b0); tick(1);
    chk("isp", 16'h0004, 16'(isp));
    u_cpu.ret(1'b0); tick(2);
    chk_irq(IAPL_CLS_CHAN, 4'h6);
    chk("chan act", 16'h0000, 16'(cact));
    clr_all();
    $display("test channel done");
    // fixed order, fatal hold and high service
    // both core flags up: only the fatal request may get through
    nest = 1;
    dis = 1;
    fat_q = 1; hi_q = 1; req = 16'h0004; tick(1);
    fat_q = 0; hi_q = 0; req = '0; tick(2);
    chk_irq(IAPL_CLS_FATAL, 4'h0);
    chk("fatal iss", 16'h0001, 16'(fiss));
    chk("high flag", 16'h0001, 16'(hflg));
    grab(1, IAPL_CLS_FATAL, 4'h0);
    nest = 0;
    dis = 0;
    fat_q = 1; tick(1); fat_q = 0; tick(2);
    chk("fatal act", 16'h0001, 16'(fact));
    chk("fatal flag", 16'h0001, 16'(fflg));
    chk("valid", 16'h0000, 16'(vld));
    chk("hold", 16'h0009, 16'(hold));
    ep = 1; u_cpu.ret(1'b1); ep = 0; tick(1);
    chk("fatal act", 16'h0001, 16'(fact));
    u_cpu.ret(1'b1); tick(2);
    chk_irq(IAPL_CLS_FATAL, 4'h0);
    grab(0, IAPL_CLS_FATAL, 4'h0); u_cpu.ret(1'b1); tick(2);
    chk_irq(IAPL_CLS_HIGH, 4'h0);
    chk("high iss", 16'h0001, 16'(hiss));
    grab(3, IAPL_CLS_HIGH, 4'h0); tick(2);
    chk("high act", 16'h0001, 16'(hact));
    chk("valid", 16'h0000, 16'(vld));
    chk("hold", 16'h0009, 16'(hold));
    ep = 1; u_cpu.ret(1'b1); ep = 0; tick(1);
    chk("high act", 16'h0001, 16'(hact));
    u_cpu.ret(1'b1); tick(2);
    chk("high act", 16'h0000, 16'(hact));
    chk_irq(IAPL_CLS_CHAN, 4'h2);
    chk("chan iss", 16'h0001, 16'(ciss));
    $display("test order done");
    results();
  end
endmodule
